// *** shared/three_wire_defines.svh ***
`ifndef THREE_WIRE_DEFINES_SVH
`define THREE_WIRE_DEFINES_SVH

// frame layout, shifted most significant bit first
`define FRAME_ADDR_W 6
`define FRAME_DIR_W 2
`define FRAME_DATA_W 8
`define FRAME_CNT_W 5
`define FRAME_ADDR_END 5'h06
`define FRAME_DIR_END 5'h08
`define FRAME_BITS 5'h10
`define FRAME_LAST_BIT 5'h0F

// direction codes
`define DIR_WRITE 2'h1
`define DIR_READ 2'h2

// regulator enable register
`define ENABLE_REG_ADDR 6'h10
`define ENABLE_RESET 8'h41

`endif

// *** shared/three_wire_pkg.sv ***
package three_wire_pkg;

	// bit 0 audio ... bit 7 reference output
	typedef struct packed {
		logic reference_output_enable;
		logic option_regulator_enable;
		logic rf_option_regulator_enable;
		logic rf_receive2_regulator_enable;
		logic rf_transmit_regulator_enable;
		logic rf_receive1_regulator_enable;
		logic vibrator_regulator_enable;
		logic audio_regulator_enable;
	} regulator_enables_type;

	typedef struct packed {
		logic [5:0] frame_address_field;
		logic [1:0] frame_direction_field;
		logic [7:0] frame_data_field;
	} frame_type;

endpackage

// *** rtl/frame_register_memory.sv ***
`timescale 1ns/1ns
`default_nettype none

// register storage written and read on the falling serial clock edge
module frame_register_memory #(
	parameter int ADDR_W = 6,
	parameter int DATA_W = 8
) (
	// clock
	input wire logic sample_clock,
	// write port
	input wire logic write_enable,
	input wire logic [ADDR_W-1:0] write_address,
	input wire logic [DATA_W-1:0] write_data,
	// read port
	input wire logic [ADDR_W-1:0] read_address,
	output logic [DATA_W-1:0] read_data
);

	logic [DATA_W-1:0] store_reg [0:(1<<ADDR_W)-1];

	always_ff @(negedge sample_clock) begin
		if (write_enable) begin
			store_reg[write_address] <= write_data;
		end
		read_data <= store_reg[read_address];
	end

endmodule

`default_nettype wire

// *** rtl/three_wire_register_port.sv ***
// Contract
// - serial clock is ignored while chip select is low
// - address, direction, then write data captured on falling serial clock edges
// - frame is 6-bit address, 2-bit direction, 8-bit data
// - direction 01 writes, 10 reads
// - every field shifts most significant bit first
// - read data driven on rising edge, host samples on falling edge
// - early chip select drop discards frame and floats the data line
// - external reset acts asynchronously on port and enable register, not on general storage
// - reset clears vibrator, rx1, tx, rx2, rf option, reference; sets audio, option
`timescale 1ns/1ns
`default_nettype none
`include "three_wire_defines.svh"

module three_wire_register_port #(
	parameter int ADDR_W = `FRAME_ADDR_W,
	parameter int DATA_W = `FRAME_DATA_W
) (
	// system clock and reset
	input wire logic clock,
	input wire logic nrst,
	// serial link
	input wire logic serial_clock_in,
	input wire logic chip_select,
	input wire logic data_in,
	output logic data_out,
	output logic data_oe,
	// regulator enables
	output three_wire_pkg::regulator_enables_type regulator_enables
);

	// link side is reset by the external reset or by the frame ending
	logic link_rst_n;
	assign link_rst_n = nrst & chip_select;

	// frame capture, falling edge of the serial clock
	logic [`FRAME_CNT_W-1:0] cnt_reg, cnt_next;
	three_wire_pkg::frame_type frame_reg, frame_next;
	logic commit_write;

	always_comb begin
		cnt_next = cnt_reg;
		frame_next = frame_reg;
		if (cnt_reg < `FRAME_ADDR_END) begin
			frame_next.frame_address_field = {frame_reg.frame_address_field[4:0], data_in};
		end else if (cnt_reg < `FRAME_DIR_END) begin
			frame_next.frame_direction_field = {frame_reg.frame_direction_field[0], data_in};
		end else if (cnt_reg < `FRAME_BITS) begin
			frame_next.frame_data_field = {frame_reg.frame_data_field[6:0], data_in};
		end
		if (cnt_reg != `FRAME_BITS) begin
			cnt_next = cnt_reg + `FRAME_CNT_W'(1);
		end
	end

	// only a whole write frame reaches storage
	assign commit_write = (cnt_reg == `FRAME_LAST_BIT)
		&& (frame_reg.frame_direction_field == `DIR_WRITE);

	always_ff @(negedge serial_clock_in or negedge link_rst_n) begin
		if (!link_rst_n) begin
			cnt_reg <= '0;
			frame_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
			frame_reg <= frame_next;
		end
	end

	// regulator enable register, survives frame end, loaded with 8'h41 by external reset only
	three_wire_pkg::regulator_enables_type enable_reg, enable_next;
	logic toggle_reg, toggle_next;

	always_comb begin
		enable_next = enable_reg;
		toggle_next = toggle_reg;
		if (commit_write && frame_reg.frame_address_field == `ENABLE_REG_ADDR) begin
			enable_next = frame_next.frame_data_field;
			toggle_next = ~toggle_reg;
		end
	end

	always_ff @(negedge serial_clock_in or negedge nrst) begin
		if (!nrst) begin
			enable_reg <= `ENABLE_RESET;
			toggle_reg <= 1'b0;
		end else begin
			enable_reg <= enable_next;
			toggle_reg <= toggle_next;
		end
	end

	// general register storage
	logic [DATA_W-1:0] mem_rdata;
	logic [DATA_W-1:0] read_byte;

	frame_register_memory #(
		.ADDR_W(ADDR_W),
		.DATA_W(DATA_W)
	) storage (
		.sample_clock(serial_clock_in),
		.write_enable(commit_write),
		.write_address(frame_reg.frame_address_field),
		.write_data(frame_next.frame_data_field),
		.read_address(frame_reg.frame_address_field),
		.read_data(mem_rdata)
	);

	assign read_byte = (frame_reg.frame_address_field == `ENABLE_REG_ADDR) ?
		enable_reg : mem_rdata;

	// read data out, rising edge of the serial clock
	logic dout_reg, dout_next;
	logic oe_reg, oe_next;
	logic read_phase;

	assign read_phase = (frame_reg.frame_direction_field == `DIR_READ)
		&& (cnt_reg >= `FRAME_DIR_END) && (cnt_reg < `FRAME_BITS);

	always_comb begin
		dout_next = 1'b0;
		oe_next = 1'b0;
		if (read_phase) begin
			oe_next = 1'b1;
			dout_next = read_byte[3'(`FRAME_LAST_BIT - cnt_reg)];
		end
	end

	always_ff @(posedge serial_clock_in or negedge link_rst_n) begin
		if (!link_rst_n) begin
			dout_reg <= 1'b0;
			oe_reg <= 1'b0;
		end else begin
			dout_reg <= dout_next;
			oe_reg <= oe_next;
		end
	end

	assign data_out = dout_reg;
	assign data_oe = oe_reg;

	// enable word held still on the link side; a synced toggle says when to take it
	// so no bit of the word is seen half changed
	logic [2:0] tsync_reg, tsync_next;
	three_wire_pkg::regulator_enables_type out_reg, out_next;

	always_comb begin
		tsync_next = {tsync_reg[1:0], toggle_reg};
		out_next = out_reg;
		if (tsync_reg[2] != tsync_reg[1]) begin
			out_next = enable_reg;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			tsync_reg <= 3'h0;
			out_reg <= `ENABLE_RESET;
		end else begin
			tsync_reg <= tsync_next;
			out_reg <= out_next;
		end
	end

	assign regulator_enables = out_reg;

	// checks
	sequence read_header_done;
		cnt_reg == `FRAME_DIR_END && frame_reg.frame_direction_field == `DIR_READ;
	endsequence

	sequence write_to_enables;
		commit_write && frame_reg.frame_address_field == `ENABLE_REG_ADDR;
	endsequence

	a_idle_ignored: assert property (
		@(posedge clock) disable iff (!nrst)
		!chip_select |-> cnt_reg == '0)
		else $error("frame counter moved while deselected");

	a_abort_float: assert property (
		@(posedge clock) disable iff (!nrst)
		!chip_select |-> !data_oe)
		else $error("data line driven while deselected");

	a_addr_msb_first: assert property (
		@(negedge serial_clock_in) disable iff (!link_rst_n)
		cnt_reg < `FRAME_ADDR_END |=>
		frame_reg.frame_address_field == {$past(frame_reg.frame_address_field[4:0]), $past(data_in)})
		else $error("address not shifted msb first");

	a_dir_capture: assert property (
		@(negedge serial_clock_in) disable iff (!link_rst_n)
		cnt_reg == 5'h07 |=>
		frame_reg.frame_direction_field == {$past(frame_reg.frame_direction_field[0]), $past(data_in)})
		else $error("direction field captured wrongly");

	a_count_stops: assert property (
		@(negedge serial_clock_in) disable iff (!link_rst_n)
		cnt_reg == `FRAME_BITS |=> cnt_reg == `FRAME_BITS)
		else $error("bit counter ran past the frame");

	a_enable_write: assert property (
		@(negedge serial_clock_in) disable iff (!nrst)
		write_to_enables |=> enable_reg == $past(frame_next.frame_data_field))
		else $error("enable register not written by write frame");

	a_read_first_bit: assert property (
		@(posedge serial_clock_in) disable iff (!link_rst_n)
		read_header_done |=> data_oe && data_out == $past(read_byte[7]))
		else $error("first read bit not driven");

	a_oe_read_only: assert property (
		@(posedge serial_clock_in) disable iff (!link_rst_n)
		!read_phase |=> !data_oe)
		else $error("data line driven outside read data phase");

	a_reset_default: assert property (
		@(posedge clock) disable iff (!nrst)
		$rose(nrst) |-> regulator_enables == `ENABLE_RESET)
		else $error("enables not at reset default");

endmodule

`default_nettype wire

// *** tb/frame_host.sv ***
`timescale 1ns/1ns
`default_nettype none

// host side of the three-wire link, 80 ns serial clock
module frame_host (
	// serial link
	output logic sclk,
	output logic cs,
	output logic din,
	input wire logic dout,
	input wire logic doe
);
	logic hv = 1'b0;
	// released line shows the current host bit hv
	assign din = doe ? dout : hv;
	initial begin
		sclk = 1'b0;
		cs = 1'b0;
	end
	// n clock pulses; sel low pulses the clock with select held low
	task automatic frame(input three_wire_pkg::frame_type f, input int n, input logic sel,
		output logic [7:0] rd, output logic [15:0] oe);
		rd = 8'h00;
		oe = 16'h0000;
		cs = sel;
		// select leads the clock by 62 us, so cut frames also stay above 31 us
		#62000;
		for (int i = 0; i < n; i++) begin
			#20;
			if (i > 15)
				hv = 1'b0;
			else if (i > 7 && f.frame_direction_field == 2'h2)
				hv = ~hv;
			else
				hv = f[15 - i];
			#20;
			sclk = 1'b1;
			#40;
			if (i < 16)
				oe[15 - i] = doe;
			if (i > 7 && i < 16)
				rd[15 - i] = din;
			sclk = 1'b0;
		end
		#40;
		cs = 1'b0;
		#62000;
	endtask
endmodule

`default_nettype wire

// *** tb/three_wire_register_port_test.sv ***
`timescale 1ns/1ns
`default_nettype none

module three_wire_register_port_test;
	logic clock, nrst, sclk, cs, din, dout, doe;
	three_wire_pkg::regulator_enables_type en;
	logic [7:0] rd;
	logic [15:0] oe;
	int errors = 0;
	int samples_checked = 0;

	three_wire_register_port dut (.clock(clock), .nrst(nrst), .serial_clock_in(sclk),
		.chip_select(cs), .data_in(din), .data_out(dout), .data_oe(doe),
		.regulator_enables(en));
	frame_host host (.sclk(sclk), .cs(cs), .din(din), .dout(dout), .doe(doe));

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	task automatic check(input string nm, input logic [15:0] e, input logic [15:0] s);
		samples_checked++;
		if (s !== e) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic xfer(input logic [5:0] a, input logic [1:0] d, input logic [7:0] v,
		input int n);
		host.frame('{a, d, v}, n, 1'b1, rd, oe);
	endtask

	// bounded wait for the enables to settle
	task automatic expect_en(input logic [7:0] e);
		for (int i = 0; i < 10 && en !== e; i++)
			@(posedge clock);
		check("enables", {8'h00, e}, {8'h00, en});
		if (en !== e)
			disable tests;
	endtask

	initial begin
		begin : tests
			nrst = 1'b0;
			repeat (6) @(posedge clock);
			#1 nrst = 1'b1;
			check("reset enables", 16'h0041, {8'h00, en});
			xfer(6'h10, 2'h1, 8'hA5, 16);
			expect_en(8'hA5);
			check("write oe", 16'h0000, oe);
			xfer(6'h10, 2'h2, 8'h00, 16);
			check("read enables", 16'h00A5, {8'h00, rd});
			check("read oe", 16'h00FF, oe);
			xfer(6'h05, 2'h1, 8'h3C, 16);
			xfer(6'h05, 2'h2, 8'hFF, 16);
			check("read storage", 16'h003C, {8'h00, rd});
			$display("write and read done");
			xfer(6'h10, 2'h2, 8'h00, 12);
			check("abort read data", 16'h00A0, {8'h00, rd});
			check("abort read oe", 16'h00F0, oe);
			check("abort read float", 16'h0000, {15'h0000, doe});
			xfer(6'h10, 2'h1, 8'h00, 12);
			check("abort oe", 16'h0000, {15'h0000, doe});
			expect_en(8'hA5);
			for (int d = 0; d < 4; d += 3) begin
				xfer(6'h10, 2'(d), 8'h00, 16);
				expect_en(8'hA5);
			end
			host.frame('{6'h10, 2'h1, 8'h00}, 16, 1'b0, rd, oe);
			expect_en(8'hA5);
			$display("refusals done");
			@(posedge clock);
			#1 nrst = 1'b0;
			#5 check("async reset", 16'h0041, {8'h00, en});
			@(posedge clock);
			#1 nrst = 1'b1;
			xfer(6'h10, 2'h1, 8'h5A, 16);
			expect_en(8'h5A);
			xfer(6'h10, 2'h1, 8'hC3, 18);
			expect_en(8'hC3);
			check("long frame oe", 16'h0000, oe);
			$display("reset done");
		end
		print_verdict();
	end
endmodule

`default_nettype wire
